// ### design/scc_conv_ctrl.sv
// Purpose: Mux decode, track/hold staging and start control of a 12-bit SAR converter.
// Assumes: APB slave; comparator and timer tick are on i_clk; trigger pin is asynchronous.
// Notes: One SAR decision per converter clock, same for both gains.
// Behaviour
// - Codes 0000-0111 pick input n as signal, analog ground as reference.
// - Codes 1010-1101 pick pairs 0/1..6/7; even is signal, odd reference.
// - Code 1111 selects zero-offset trim; 1000, 1001, 1110 select nothing.
// - Unity gain: track plus conversion takes 16 converter clocks.
// - Gain 16: amplify, track and conversion take 26.5 clocks, here 27.
// - Unity gain: track signal and reference, then convert difference to 12 bits.
// - Gain 16: amplifier tracks and holds first, then converter tracks and converts.
// - Bit-decision sequence identical for both gains; only staging differs.
// - Throughput reaches 125ksps at unity and 75.5ksps at gain 16; here continuous mode repeats every 17 and 28 clocks.
// - Starts come from software bit, continuous mode, timer or external pin.
// - External trigger starts on selected edge; software makes the pin an input.
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "scc_defines.svh"
module scc_conv_ctrl
    import scc_pkg::*;
(
    input wire logic i_clk, // Converter clock, 2 MHz
    input wire logic i_reset, // Async reset, high
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire logic i_comp, // Comparator, high keeps trial bit
    input wire logic i_timer_tick, // Internal timer zero event
    input wire logic i_ext_trig, // External convert trigger pin
    output scc_mux_s o_mux, // Input multiplexer setting
    output logic o_pga_track, // Amplifier tracking
    output logic o_pga_hold, // Amplifier holding
    output logic o_adc_track, // Sampling capacitors tracking
    output logic o_sar_active, // Bit decisions running
    output scc_code_t o_dac_code, // Trial code to the DAC
    output logic o_busy // Conversion in progress
);
    localparam logic [4:0] G1_CYC = 5'(`SCC_G1_CYC);
    localparam logic [4:0] G16_CYC = 5'(`SCC_G16_CYC);
    localparam logic [4:0] TRACK_LAST = 5'(`SCC_TRACK_CYC - 1);
    localparam logic [4:0] AMP_LAST = 5'(`SCC_AMP_CYC - 1);
    localparam logic [4:0] BIT_LAST = 5'(`SCC_BITS - 1);

    // APB and register state
    logic [31:0] ctrl_r, ctrl_nxt, prdata_nxt;
    logic pready_nxt, pslverr_nxt, done_r, done_nxt, sw_pend_r, sw_pend_nxt;
    logic wr_en, rd_setup;
    scc_code_t res_rdata;

    // Sequencer state
    scc_state_e state_r, state_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    scc_code_t sar_r, sar_nxt, dac_nxt, res_word;
    logic g16_r, g16_nxt, conv_end, start;
    logic [3:0] chan_r, chan_nxt;
    scc_mux_s mux_nxt;
    logic pga_track_nxt, pga_hold_nxt, adc_track_nxt, sar_act_nxt;

    // Trigger pin synchroniser and edge detect
    logic ext_s1_r, ext_s2_r, ext_s3_r, ext_edge;

    wire [2:0] mode = ctrl_r[`SCC_CTRL_MODE_LO +: 3];
    wire [3:0] ctrl_chan = ctrl_r[`SCC_CTRL_CHAN_LO +: 4];

    assign wr_en = psel && penable && pready && pwrite;
    assign rd_setup = psel && !penable;

    always_comb begin
        pready_nxt = rd_setup;
        pslverr_nxt = 1'b0;
        prdata_nxt = prdata;
        if (rd_setup) begin
            prdata_nxt = 32'h0000_0000;
            unique case (paddr)
                `SCC_OFS_CTRL: prdata_nxt = ctrl_r;
                `SCC_OFS_STAT: begin
                    prdata_nxt[`SCC_STAT_DONE_BIT] = done_r;
                    prdata_nxt[`SCC_STAT_BUSY_BIT] = o_busy;
                end
                `SCC_OFS_RES: prdata_nxt[11:0] = res_rdata;
                default: pslverr_nxt = 1'b1;
            endcase
        end else if (psel) begin
            pslverr_nxt = pslverr;
        end
        ctrl_nxt = ctrl_r;
        if (wr_en && paddr == `SCC_OFS_CTRL) begin
            ctrl_nxt = pwdata & `SCC_CTRL_WMASK;
        end
        // Start request stays pending until taken; a new write wins
        sw_pend_nxt = sw_pend_r;
        if (start) begin
            sw_pend_nxt = 1'b0;
        end
        if (wr_en && paddr == `SCC_OFS_CTRL && pwdata[`SCC_CTRL_SWGO_BIT]) begin
            sw_pend_nxt = 1'b1;
        end
        // Write one to clear; a completing conversion in the same cycle wins
        done_nxt = done_r;
        if (wr_en && paddr == `SCC_OFS_STAT && pwdata[`SCC_STAT_DONE_BIT]) begin
            done_nxt = 1'b0;
        end
        if (conv_end) begin
            done_nxt = 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ctrl_r <= `SCC_CTRL_RESET;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            done_r <= 1'b0;
            sw_pend_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            prdata <= prdata_nxt;
            pready <= pready_nxt;
            pslverr <= pslverr_nxt;
            done_r <= done_nxt;
            sw_pend_r <= sw_pend_nxt;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
        end else begin
            ext_s1_r <= i_ext_trig;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
        end
    end

    // Pin must be an input in the port logic, else the device drives it
    always_comb begin
        if (ctrl_r[`SCC_CTRL_EDGE_BIT]) begin
            ext_edge = ext_s2_r && !ext_s3_r;
        end else begin
            ext_edge = !ext_s2_r && ext_s3_r;
        end
    end

    // Triggers arriving mid-conversion are dropped, except the software bit
    always_comb begin
        start = 1'b0;
        if (state_r == SCC_IDLE) begin
            unique case (mode)
                `SCC_MODE_SW: start = sw_pend_r;
                `SCC_MODE_CONT: start = 1'b1;
                `SCC_MODE_TIMER: start = i_timer_tick;
                `SCC_MODE_EXT: start = ext_edge;
                default: start = 1'b0;
            endcase
        end
    end

    assign conv_end = state_r == SCC_CONV && cnt_r == BIT_LAST;
    assign res_word = i_comp ? o_dac_code : sar_r;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r + 5'd1;
        sar_nxt = sar_r;
        dac_nxt = o_dac_code;
        g16_nxt = g16_r;
        chan_nxt = chan_r;
        unique case (state_r)
            SCC_IDLE: begin
                cnt_nxt = 5'd0;
                if (start) begin
                    g16_nxt = ctrl_r[`SCC_CTRL_GAIN_BIT];
                    chan_nxt = ctrl_chan;
                    state_nxt = ctrl_r[`SCC_CTRL_GAIN_BIT] ? SCC_AMP : SCC_TRACK;
                end
            end
            SCC_AMP: begin
                if (cnt_r == AMP_LAST) begin
                    cnt_nxt = 5'd0;
                    state_nxt = SCC_TRACK;
                end
            end
            SCC_TRACK: begin
                if (cnt_r == TRACK_LAST) begin
                    cnt_nxt = 5'd0;
                    sar_nxt = 12'h000;
                    dac_nxt = 12'h800;
                    state_nxt = SCC_CONV;
                end
            end
            SCC_CONV: begin
                // Same decision loop whatever the gain
                sar_nxt = res_word;
                dac_nxt = res_word | (12'h400 >> cnt_r);
                if (conv_end) begin
                    cnt_nxt = 5'd0;
                    state_nxt = SCC_IDLE;
                end
            end
        endcase
        pga_track_nxt = state_nxt == SCC_AMP;
        pga_hold_nxt = g16_nxt && (state_nxt == SCC_TRACK || state_nxt == SCC_CONV);
        adc_track_nxt = state_nxt == SCC_TRACK;
        sar_act_nxt = state_nxt == SCC_CONV;
    end

    // Reserved codes leave the mux open
    always_comb begin
        mux_nxt = '0;
        if (!chan_nxt[3]) begin
            mux_nxt.en = 1'b1;
            mux_nxt.sig = chan_nxt[2:0];
            mux_nxt.ref_gnd = 1'b1;
        end else if (chan_nxt >= `SCC_CH_DIFF_LO && chan_nxt <= `SCC_CH_DIFF_HI) begin
            mux_nxt.en = 1'b1;
            mux_nxt.sig = {chan_nxt[1:0] - 2'd2, 1'b0};
            mux_nxt.refch = {chan_nxt[1:0] - 2'd2, 1'b1};
        end else if (chan_nxt == `SCC_CH_TRIM) begin
            mux_nxt.en = 1'b1;
            mux_nxt.trim = 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_r <= SCC_IDLE;
            cnt_r <= 5'd0;
            sar_r <= 12'h000;
            o_dac_code <= 12'h000;
            g16_r <= 1'b0;
            chan_r <= 4'h0;
            o_mux <= '0;
            o_pga_track <= 1'b0;
            o_pga_hold <= 1'b0;
            o_adc_track <= 1'b0;
            o_sar_active <= 1'b0;
            o_busy <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            sar_r <= sar_nxt;
            o_dac_code <= dac_nxt;
            g16_r <= g16_nxt;
            chan_r <= chan_nxt;
            o_mux <= mux_nxt;
            o_pga_track <= pga_track_nxt;
            o_pga_hold <= pga_hold_nxt;
            o_adc_track <= adc_track_nxt;
            o_sar_active <= sar_act_nxt;
            o_busy <= state_nxt != SCC_IDLE;
        end
    end

    scc_result_store u_scc_result_store (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_we(conv_end),
        .i_wdata(res_word),
        .o_rdata(res_rdata)
    );

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    property p_se_route;
        start && !ctrl_chan[3] |=> o_mux.en && o_mux.ref_gnd && o_mux.sig == $past(ctrl_chan[2:0]);
    endproperty
    a_se_route: assert property (p_se_route) else $error("single-ended routing wrong");

    property p_diff_route;
        start && ctrl_chan == 4'hb |=> o_mux.sig == 3'd2 && o_mux.refch == 3'd3 && !o_mux.ref_gnd;
    endproperty
    a_diff_route: assert property (p_diff_route) else $error("differential pair wrong");

    property p_reserved;
        start && (ctrl_chan == 4'h8 || ctrl_chan == 4'h9 || ctrl_chan == 4'he) |=> !o_mux.en;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved code selected an input");

    property p_g1_len;
        start && !ctrl_r[`SCC_CTRL_GAIN_BIT] |-> ##16 conv_end;
    endproperty
    a_g1_len: assert property (p_g1_len) else $error("unity gain cycle not 16 clocks");

    property p_g16_len;
        start && ctrl_r[`SCC_CTRL_GAIN_BIT] |-> ##27 conv_end;
    endproperty
    a_g16_len: assert property (p_g16_len) else $error("gain 16 cycle not 27 clocks");

    property p_g1_track;
        start && !ctrl_r[`SCC_CTRL_GAIN_BIT] |-> ##1 (o_adc_track && !o_pga_hold)[*4] ##1 (o_sar_active && !o_adc_track);
    endproperty
    a_g1_track: assert property (p_g1_track) else $error("unity gain track/hold wrong");

    property p_g16_stage;
        start && ctrl_r[`SCC_CTRL_GAIN_BIT] |-> ##1 o_pga_track ##11 (o_adc_track && o_pga_hold && !o_pga_track);
    endproperty
    a_g16_stage: assert property (p_g16_stage) else $error("gain 16 staging wrong");

    property p_sar_len;
        $rose(o_sar_active) |-> ##11 conv_end ##1 !o_sar_active;
    endproperty
    a_sar_len: assert property (p_sar_len) else $error("bit decisions not 12 clocks");

    property p_cont;
        conv_end && mode == `SCC_MODE_CONT |=> start;
    endproperty
    a_cont: assert property (p_cont) else $error("continuous restart late");

    property p_ext;
        state_r == SCC_IDLE && mode == `SCC_MODE_EXT && ext_edge |=> o_busy;
    endproperty
    a_ext: assert property (p_ext) else $error("external edge did not start");

    property p_sw;
        state_r == SCC_IDLE && mode == `SCC_MODE_SW && sw_pend_r |=> o_busy && !sw_pend_r;
    endproperty
    a_sw: assert property (p_sw) else $error("software start not taken");

    property p_done;
        conv_end |=> done_r && !o_busy;
    endproperty
    a_done: assert property (p_done) else $error("done flag not set");

    c_g1: cover property (start && !ctrl_r[`SCC_CTRL_GAIN_BIT] ##16 conv_end);
    c_g16: cover property (start && ctrl_r[`SCC_CTRL_GAIN_BIT] ##27 conv_end);
    c_ext: cover property (start && mode == `SCC_MODE_EXT);
    c_clr_race: cover property (conv_end && wr_en && paddr == `SCC_OFS_STAT);
endmodule
`default_nettype wire

// ### design/scc_defines.svh
// Purpose: Offsets, fields, reset values and stage counts of the converter control.
// Assumes: Converter clock is the block clock i_clk.
// Notes: Counts are in converter clock periods, except SCC_G1_HALF and SCC_G16_HALF, which are in half periods.
`ifndef SCC_DEFINES_SVH
`define SCC_DEFINES_SVH

`define SCC_OFS_CTRL 8'h00
`define SCC_OFS_STAT 8'h04
`define SCC_OFS_RES 8'h08

`define SCC_CTRL_MODE_LO 0
`define SCC_CTRL_EDGE_BIT 3
`define SCC_CTRL_SWGO_BIT 4
`define SCC_CTRL_CHAN_LO 11
`define SCC_CTRL_GAIN_BIT 15
`define SCC_CTRL_RESET 32'h0000_0000
`define SCC_CTRL_WMASK 32'h0000_f80f

`define SCC_STAT_DONE_BIT 0
`define SCC_STAT_BUSY_BIT 1

`define SCC_MODE_SW 3'h0
`define SCC_MODE_CONT 3'h1
`define SCC_MODE_TIMER 3'h2
`define SCC_MODE_EXT 3'h3

`define SCC_CH_DIFF_LO 4'ha
`define SCC_CH_DIFF_HI 4'hd
`define SCC_CH_TRIM 4'hf

// Whole cycle lengths in half converter clocks; a half cycle rounds up
`define SCC_G1_HALF 32
`define SCC_G16_HALF 53
`define SCC_G1_CYC ((`SCC_G1_HALF + 1) / 2)
`define SCC_G16_CYC ((`SCC_G16_HALF + 1) / 2)
`define SCC_BITS 12
`define SCC_TRACK_CYC (`SCC_G1_CYC - `SCC_BITS)
`define SCC_AMP_CYC (`SCC_G16_CYC - `SCC_G1_CYC)

`endif

// ### design/scc_pkg.sv
// Purpose: Types shared by the converter control files.
// Assumes: Constants live in scc_defines.svh.
// Notes: None.
package scc_pkg;
    typedef enum logic [1:0] {SCC_IDLE, SCC_AMP, SCC_TRACK, SCC_CONV} scc_state_e;
    typedef struct packed {
        logic en;
        logic [2:0] sig;
        logic [2:0] refch;
        logic ref_gnd;
        logic trim;
    } scc_mux_s;
    typedef logic [11:0] scc_code_t;
endpackage

// ### design/scc_result_store.sv
// Purpose: Holds the last conversion result.
// Assumes: Write enable is a one-cycle pulse.
// Notes: Read data comes straight from the storage flop.
`timescale 1ns/1ps
`default_nettype none
module scc_result_store
    import scc_pkg::*;
(
    input wire logic i_clk, // Converter clock
    input wire logic i_reset, // Async reset, high
    input wire logic i_we, // Store strobe
    input wire scc_code_t i_wdata, // Result to store
    output scc_code_t o_rdata // Stored result
);
    scc_code_t data_r;
    scc_code_t data_nxt;

    always_comb begin
        data_nxt = i_we ? i_wdata : data_r;
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            data_r <= 12'h000;
        end else begin
            data_r <= data_nxt;
        end
    end

    assign o_rdata = data_r;
endmodule
`default_nettype wire

// ### testbench/scc_comp_model.sv
// Purpose: Comparator and analog mux stand-in for the converter control.
// Assumes: Each mux setting maps to its own fixed input level.
// Notes: Outside bit decisions the output toggles so stale values never help.
`timescale 1ns/1ps
`default_nettype none
module scc_comp_model
    import scc_pkg::*;
(
    input wire logic i_clk, // Converter clock
    input wire scc_mux_s i_mux, // Mux setting from the block
    input wire scc_code_t i_dac_code, // Trial code
    input wire logic i_sar_active, // Bit decisions running
    output logic o_comp // High keeps the trial bit
);
    scc_code_t level;
    logic tog_r = 1'b0;
    always_comb begin
        if (i_mux.trim) begin
            level = 12'h7ff;
        end else if (i_mux.ref_gnd) begin
            level = {i_mux.sig, 9'h0a5};
        end else begin
            level = {i_mux.sig, i_mux.refch, 6'h1c};
        end
    end
    // Plain always: the declaration gives the starting value
    always @(posedge i_clk) begin
        tog_r <= ~tog_r;
    end
    // Trial at or below the level keeps the bit, so the result lands on the level
    assign o_comp = i_sar_active ? (i_dac_code <= level) : tog_r;
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
// Purpose: Self-checking bench for the converter control.
// Assumes: Zero-wait APB slave; comparator model on the far side.
// Notes: Read data is checked by a monitor against queued expectations.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import scc_pkg::*;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic i_comp;
    logic i_timer_tick = 1'b0;
    logic i_ext_trig = 1'b0; // Pin used as input only
    scc_mux_s o_mux;
    logic o_pga_track, o_pga_hold, o_adc_track, o_sar_active, o_busy;
    scc_code_t o_dac_code;
    logic last_err;
    int failures = 0;
    int num_checks = 0;
    logic [31:0] exp_q[$];
    logic [31:0] c;
    logic [3:0] k;
    logic g;
    logic [1:0] p;

    always #10 i_clk = ~i_clk;

    scc_conv_ctrl u_scc_conv_ctrl (.i_clk(i_clk), .i_reset(i_reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .i_comp(i_comp), .i_timer_tick(i_timer_tick), .i_ext_trig(i_ext_trig),
        .o_mux(o_mux), .o_pga_track(o_pga_track), .o_pga_hold(o_pga_hold), .o_adc_track(o_adc_track),
        .o_sar_active(o_sar_active), .o_dac_code(o_dac_code), .o_busy(o_busy));
    scc_comp_model u_scc_comp_model (.i_clk(i_clk), .i_mux(o_mux), .i_dac_code(o_dac_code),
        .i_sar_active(o_sar_active), .o_comp(i_comp));

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic timeout();
        failures++;
        $display("ERROR %0t: wait ran out", $time);
        final_report();
    endtask

    // Read data is valid at the access edge only
    always @(posedge i_clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (exp_q.size() == 0) begin
                timeout();
            end else begin
                check(prdata, exp_q.pop_front());
            end
        end
    end

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
            if (n > 20) timeout();
        end while (pready !== 1'b1);
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        exp_q.push_back(exp);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic wait_busy(input logic v, input int bound);
        int n;
        n = 0;
        while (o_busy !== v) begin
            @(posedge i_clk);
            #1;
            n++;
            if (n > bound) timeout();
        end
    endtask

    task automatic conv(input logic [31:0] ctrl, input int len, input int amp);
        int nb = 0, ns = 0, nt = 0, np = 0, nh = 0;
        apb(1'b1, 8'h00, ctrl);
        wait_busy(1'b1, 6);
        while (o_busy === 1'b1) begin
            nb++;
            // First trial is midscale
            if (ns == 0 && o_sar_active === 1'b1) begin
                check(32'(o_dac_code), 32'h800);
            end
            ns += int'(o_sar_active);
            nt += int'(o_adc_track);
            np += int'(o_pga_track);
            nh += int'(o_pga_hold);
            @(posedge i_clk);
            #1;
            if (nb > 60) timeout();
        end
        check(32'(nb), 32'(len));
        check(32'(ns), 32'd12);
        check(32'(nt), 32'd4);
        check(32'(np), 32'(amp));
        check(32'(nh), (amp != 0) ? 32'd16 : 32'd0);
    endtask

    initial begin
        void'($urandom(41906));
        repeat (4) @(posedge i_clk);
        i_reset <= 1'b0;
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h0);
        rd(8'h10, 32'h0);
        check(32'(last_err), 32'h1);
        $display("Test reset and map done");
        for (int i = 0; i < 16; i++) begin
            k = 4'(i);
            // First two codes pin both gains; the rest are random
            g = (i < 2) ? 1'(i) : 1'($urandom);
            // Pair index counts up from the first differential code
            p = 2'(k - 4'ha);
            c = {16'h0, g, k, 11'h010};
            conv(c, g ? 27 : 16, g ? 11 : 0);
            rd(8'h00, c & 32'hffff_ffef);
            if (k < 4'h8) begin
                check({o_mux.en, o_mux.sig, o_mux.ref_gnd, o_mux.trim}, {1'b1, k[2:0], 2'b10});
                rd(8'h08, {20'h0, k[2:0], 9'h0a5});
            end else if (k >= 4'ha && k <= 4'hd) begin
                check({o_mux.en, o_mux.sig, o_mux.refch, o_mux.ref_gnd, o_mux.trim},
                    {1'b1, p, 1'b0, p, 1'b1, 2'b00});
                rd(8'h08, {20'h0, p, 1'b0, p, 1'b1, 6'h1c});
            end else if (k == 4'hf) begin
                check({o_mux.en, o_mux.trim}, 2'b11);
                rd(8'h08, 32'h7ff);
            end else begin
                check(o_mux.en, 1'b0);
            end
            rd(8'h04, 32'h1);
            apb(1'b1, 8'h04, 32'h1);
            rd(8'h04, 32'h0);
        end
        $display("Test channel codes done");
        apb(1'b1, 8'h00, 32'h1);
        wait_busy(1'b1, 6);
        wait_busy(1'b0, 40);
        wait_busy(1'b1, 2);
        apb(1'b1, 8'h00, 32'h0);
        wait_busy(1'b0, 40);
        repeat (3) @(posedge i_clk);
        wait_busy(1'b0, 40);
        #1;
        check(32'(o_busy), 32'h0);
        $display("Test continuous done");
        apb(1'b1, 8'h00, 32'h2);
        i_timer_tick <= 1'b1;
        @(posedge i_clk);
        i_timer_tick <= 1'b0;
        wait_busy(1'b1, 3);
        @(posedge i_clk);
        i_timer_tick <= 1'b1;
        @(posedge i_clk);
        i_timer_tick <= 1'b0;
        wait_busy(1'b0, 40);
        repeat (3) @(posedge i_clk);
        #1;
        check(32'(o_busy), 32'h0);
        $display("Test timer done");
        apb(1'b1, 8'h00, 32'h3);
        @(posedge i_clk);
        i_ext_trig <= 1'b1;
        repeat (6) @(posedge i_clk);
        #1;
        check(32'(o_busy), 32'h0);
        @(posedge i_clk);
        i_ext_trig <= 1'b0;
        wait_busy(1'b1, 6);
        wait_busy(1'b0, 40);
        apb(1'b1, 8'h00, 32'hb);
        @(posedge i_clk);
        i_ext_trig <= 1'b1;
        wait_busy(1'b1, 6);
        wait_busy(1'b0, 40);
        $display("Test external trigger done");
        final_report();
    end
endmodule
`default_nettype wire
